/* rtl/drive_status_flags.v */
// status and diagnostic flag logic of the drive controller
`timescale 1ns/100ps
`include "drive_status_defines.vh"

// How it works
// - on a trip, real-valued readouts freeze until drive reset.
// - forward flag set only when running forward above zero speed threshold.
// - reverse flag set only when running reverse above zero speed threshold.
// - encoder feedback: A leading B is forward, A lagging B reverse.
// - both direction flags clear gives zero speed flag and indicator.
// - current-limit flag while demand plus offset is being limited.
// - bridge flags follow firing of forward and reverse bridges.
// - phase-back flag while standstill function phases back firing.
// - at-speed when ramp output equals input and error under 1.5 percent.
// - overspeed flag when feedback exceeds 1000; never trips.
// - zero speed flag when feedback below programmed threshold.
// - clamp flag while active; armature voltage increase is blocked.
// - phase sequence bit: 0 for L1 L3 L2, 1 for L1 L2 L3.
// - healthy flag high only when powered and no trip.
// - overload alarm flag and flashing indicator while overload builds.
// - field loss flag when no field current; no trip in direct firing mode.
// - feedback loss only beyond firing angle 767; trip may be disabled.
// - supply loss flag on missing phase unless detection disabled.
// - peak above twice rated current sets flag, kills firing at once.
// - overload accumulator rises by excess, falls toward zero, own rates.
// - each rate scales its step: excess or deficit times rate, over 16, per cycle.
// - processor restarts watchdog; expiry forces shutdown and sets fault flag.
module drive_status_flags #(
  parameter [23:0] WATCHDOG_LIMIT = `WATCHDOG_CYCLES
) (
  input wire clock,
  input wire sys_rst,
  input wire signed [11:0] speed_feedback,
  input wire signed [11:0] final_speed_demand,
  input wire signed [11:0] pre_ramp_reference,
  input wire signed [11:0] post_ramp_reference,
  input wire [11:0] zero_speed_threshold,
  input wire encoder_selected,
  input wire encoder_a,
  input wire encoder_b,
  input wire current_demand_limited,
  input wire forward_bridge_fire,
  input wire reverse_bridge_fire,
  input wire standstill_phaseback,
  input wire clamp_active,
  input wire phase_order_l1_l2_l3,
  input wire signed [11:0] current_feedback,
  input wire [11:0] overload_threshold,
  input wire [15:0] overload_rise_rate,
  input wire [15:0] overload_fall_rate,
  input wire field_current_absent,
  input wire direct_firing_selected,
  input wire speed_feedback_absent,
  input wire [10:0] firing_angle,
  input wire feedback_loss_disable,
  input wire phase_missing,
  input wire supply_loss_disable,
  input wire current_peak_over,
  input wire watchdog_restart,
  input wire [11:0] armature_voltage_demand,
  output reg forward_running_flag,
  output reg reverse_running_flag,
  output reg current_limit_flag,
  output reg forward_bridge_firing_flag,
  output reg reverse_bridge_firing_flag,
  output reg standstill_phaseback_flag,
  output reg at_speed_flag,
  output reg overspeed_flag,
  output reg zero_speed_flag,
  output reg zero_speed_indicator,
  output reg voltage_clamp_flag,
  output reg phase_sequence_flag,
  output reg drive_ok_flag,
  output reg overload_alarm_flag,
  output reg alarm_indicator,
  output reg field_failure_flag,
  output reg speed_feedback_missing_flag,
  output reg phase_missing_flag,
  output reg overcurrent_peak_flag,
  output reg sustained_overload_flag,
  output reg watchdog_fault_flag,
  output reg firing_enable,
  output reg [11:0] armature_voltage_limited,
  output reg signed [11:0] speed_readout,
  output reg [11:0] current_readout,
  output reg [23:0] overload_readout
);
  wire [23:0] overload_level;
  wire overload_alarm;
  wire overload_full;
  wire [11:0] speed_mag;
  wire [11:0] current_mag;
  wire signed [12:0] speed_error;
  wire [12:0] speed_error_mag;
  wire beyond_zero;
  wire encoder_forward;
  wire moving_forward;
  wire moving_reverse;
  wire feedback_check;
  wire trip_now;
  wire trip_active;
  reg a_prev_reg;
  reg b_prev_reg;
  reg encoder_dir_reg;
  reg tripped_reg;
  reg field_trip_reg;
  reg feedback_trip_reg;
  reg supply_trip_reg;
  reg [23:0] watchdog_cnt_reg;
  reg [21:0] flash_cnt_reg;

  overload_integrator overload_unit (
    .clock(clock),
    .sys_rst(sys_rst),
    .current_feedback(current_feedback),
    .overload_threshold(overload_threshold),
    .rise_rate(overload_rise_rate),
    .fall_rate(overload_fall_rate),
    .overload_level_reg(overload_level),
    .alarm_reg(overload_alarm),
    .full_reg(overload_full)
  );

  assign speed_mag = speed_feedback[11] ? (12'h000 - speed_feedback) : speed_feedback;
  assign current_mag = current_feedback[11] ? (12'h000 - current_feedback) : current_feedback;
  assign beyond_zero = speed_mag >= zero_speed_threshold;
  // quadrature phase: a edge with b low after rise means a leads b
  assign encoder_forward = encoder_dir_reg;
  assign moving_forward = beyond_zero &&
    (encoder_selected ? encoder_forward : !speed_feedback[11]);
  assign moving_reverse = beyond_zero &&
    (encoder_selected ? !encoder_forward : speed_feedback[11]);
  assign speed_error = {final_speed_demand[11], final_speed_demand}
    - {speed_feedback[11], speed_feedback};
  assign speed_error_mag = speed_error[12] ? (13'h0000 - speed_error) : speed_error;
  assign feedback_check = firing_angle > `FIRING_FEEDBACK_MIN;
  assign trip_now = current_peak_over || (watchdog_cnt_reg >= WATCHDOG_LIMIT) || overload_full
    || (field_current_absent && !direct_firing_selected)
    || (speed_feedback_absent && feedback_check && !feedback_loss_disable)
    || (phase_missing && !supply_loss_disable);
  assign trip_active = tripped_reg || trip_now;

  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      a_prev_reg <= 1'b0;
      b_prev_reg <= 1'b0;
      encoder_dir_reg <= 1'b1;
    end
    else
    begin
      a_prev_reg <= encoder_a;
      b_prev_reg <= encoder_b;
      if (encoder_a != a_prev_reg)
        encoder_dir_reg <= encoder_a ^ encoder_b;
      else if (encoder_b != b_prev_reg)
        encoder_dir_reg <= !(encoder_a ^ encoder_b);
    end
  end

  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      forward_running_flag <= 1'b0;
      reverse_running_flag <= 1'b0;
      current_limit_flag <= 1'b0;
      forward_bridge_firing_flag <= 1'b0;
      reverse_bridge_firing_flag <= 1'b0;
      standstill_phaseback_flag <= 1'b0;
      at_speed_flag <= 1'b0;
      overspeed_flag <= 1'b0;
      zero_speed_flag <= 1'b1;
      zero_speed_indicator <= 1'b1;
      voltage_clamp_flag <= 1'b0;
      phase_sequence_flag <= 1'b0;
      armature_voltage_limited <= 12'h000;
    end
    else
    begin
      forward_running_flag <= moving_forward;
      reverse_running_flag <= moving_reverse;
      zero_speed_flag <= speed_mag < zero_speed_threshold;
      zero_speed_indicator <= !moving_forward && !moving_reverse;
      current_limit_flag <= current_demand_limited;
      forward_bridge_firing_flag <= forward_bridge_fire;
      reverse_bridge_firing_flag <= reverse_bridge_fire;
      standstill_phaseback_flag <= standstill_phaseback;
      at_speed_flag <= (post_ramp_reference == pre_ramp_reference)
        && (speed_error_mag[11:0] < `AT_SPEED_ERR_MAX) && !speed_error_mag[12];
      overspeed_flag <= speed_feedback > `SPEED_FULL_SCALE;
      voltage_clamp_flag <= clamp_active;
      if (!clamp_active || armature_voltage_demand < armature_voltage_limited)
        armature_voltage_limited <= armature_voltage_demand;
      phase_sequence_flag <= phase_order_l1_l2_l3;
    end
  end

  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      tripped_reg <= 1'b0;
      drive_ok_flag <= 1'b0;
      firing_enable <= 1'b0;
      overload_alarm_flag <= 1'b0;
      alarm_indicator <= 1'b0;
      flash_cnt_reg <= 22'h000000;
      field_failure_flag <= 1'b0;
      field_trip_reg <= 1'b0;
      speed_feedback_missing_flag <= 1'b0;
      feedback_trip_reg <= 1'b0;
      phase_missing_flag <= 1'b0;
      supply_trip_reg <= 1'b0;
      overcurrent_peak_flag <= 1'b0;
      sustained_overload_flag <= 1'b0;
      watchdog_fault_flag <= 1'b0;
      watchdog_cnt_reg <= 24'h000000;
    end
    else
    begin
      tripped_reg <= trip_active;
      drive_ok_flag <= !trip_active;
      firing_enable <= !trip_active;
      overload_alarm_flag <= overload_alarm;
      flash_cnt_reg <= flash_cnt_reg + 22'h000001;
      alarm_indicator <= overload_alarm && flash_cnt_reg[21];
      field_failure_flag <= field_current_absent;
      field_trip_reg <= field_trip_reg || (field_current_absent && !direct_firing_selected);
      speed_feedback_missing_flag <= speed_feedback_absent && feedback_check;
      feedback_trip_reg <= feedback_trip_reg
        || (speed_feedback_absent && feedback_check && !feedback_loss_disable);
      phase_missing_flag <= phase_missing && !supply_loss_disable;
      supply_trip_reg <= supply_trip_reg || (phase_missing && !supply_loss_disable);
      if (current_peak_over)
        overcurrent_peak_flag <= 1'b1;
      if (overload_full)
        sustained_overload_flag <= 1'b1;
      if (watchdog_cnt_reg >= WATCHDOG_LIMIT)
        watchdog_fault_flag <= 1'b1;
      if (watchdog_restart)
        watchdog_cnt_reg <= 24'h000000;
      else if (watchdog_cnt_reg < WATCHDOG_LIMIT)
        watchdog_cnt_reg <= watchdog_cnt_reg + 24'h000001;
    end
  end

  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      speed_readout <= 12'h000;
      current_readout <= 12'h000;
      overload_readout <= 24'h000000;
    end
    else if (!trip_active)
    begin
      speed_readout <= speed_feedback;
      current_readout <= current_mag;
      overload_readout <= overload_level;
    end
  end
endmodule // drive_status_flags

/* rtl/overload_integrator.v */
// i x t overload accumulator with separate rise and fall rates
`timescale 1ns/100ps
module overload_integrator (
  input wire clock,
  input wire sys_rst,
  input wire signed [11:0] current_feedback,
  input wire [11:0] overload_threshold,
  input wire [15:0] rise_rate,
  input wire [15:0] fall_rate,
  output reg [23:0] overload_level_reg,
  output reg alarm_reg,
  output reg full_reg
);
  wire [11:0] current_mag;
  wire above;
  wire [11:0] excess;
  wire [11:0] deficit;
  wire [27:0] rise_step;
  wire [27:0] fall_step;
  reg [23:0] overload_level_next;

  assign current_mag = current_feedback[11] ? (12'h000 - current_feedback) : current_feedback;
  assign above = current_mag > overload_threshold;
  assign excess = current_mag - overload_threshold;
  assign deficit = overload_threshold - current_mag;
  // step per cycle scaled so full-scale overload reaches the top in the programmed time
  assign rise_step = excess * rise_rate;
  assign fall_step = deficit * fall_rate;

  always @*
  begin
    overload_level_next = overload_level_reg;
    if (above)
    begin
      if ({4'h0, overload_level_reg} + rise_step[27:4] >= {4'h0, `OVERLOAD_FULL})
        overload_level_next = `OVERLOAD_FULL;
      else
        overload_level_next = overload_level_reg + rise_step[27:4];
    end
    else if (overload_level_reg > fall_step[27:4])
      overload_level_next = overload_level_reg - fall_step[27:4];
    else
      overload_level_next = 24'h000000;
  end

  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      overload_level_reg <= 24'h000000;
      alarm_reg <= 1'b0;
      full_reg <= 1'b0;
    end
    else
    begin
      overload_level_reg <= overload_level_next;
      alarm_reg <= above && (overload_level_next != 24'h000000);
      full_reg <= overload_level_next == `OVERLOAD_FULL;
    end
  end
endmodule // overload_integrator

/* shared/drive_status_defines.vh */
// constants for the drive status and diagnostic flag block
`ifndef DRIVE_STATUS_DEFINES_VH
`define DRIVE_STATUS_DEFINES_VH

`define SPEED_W 12
`define SPEED_FULL_SCALE 12'sh3E8
`define FIRING_FEEDBACK_MIN 11'h2FF
`define AT_SPEED_ERR_MAX 12'h00F
`define OVERLOAD_W 24
`define OVERLOAD_FULL 24'hFFFFFF
`define CLOCK_HZ 50000000
`define CLOCK_NS 20
`define WATCHDOG_TIMEOUT_US 1000
`define WATCHDOG_CYCLES ((`WATCHDOG_TIMEOUT_US * 1000) / `CLOCK_NS)
`define WATCHDOG_CNT_W 24

`endif

/* tb/drive_status_flags_assertions.sv */
// concurrent checks on the drive status flag block
`timescale 1ns/100ps
module drive_status_checker #(
  parameter [23:0] WATCHDOG_LIMIT = 24'h00C350
) (
  input wire clock,
  input wire sys_rst,
  input wire signed [11:0] speed_feedback,
  input wire forward_bridge_fire,
  input wire current_peak_over,
  input wire speed_feedback_absent,
  input wire [10:0] firing_angle,
  input wire clamp_active,
  input wire watchdog_restart,
  input wire forward_bridge_firing_flag,
  input wire forward_running_flag,
  input wire reverse_running_flag,
  input wire overspeed_flag,
  input wire zero_speed_indicator,
  input wire drive_ok_flag,
  input wire firing_enable,
  input wire overcurrent_peak_flag,
  input wire speed_feedback_missing_flag,
  input wire watchdog_fault_flag,
  input wire signed [11:0] speed_readout,
  input wire [11:0] armature_voltage_limited
);
  reg [23:0] idle_reg;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  // cycles since the last watchdog restart
  always @(posedge clock)
    if (sys_rst || watchdog_restart)
      idle_reg <= 24'h000000;
    else if (idle_reg != 24'hFFFFFF)
      idle_reg <= idle_reg + 24'h000001;
  chk_bridge_follow: assert property (forward_bridge_fire |=> forward_bridge_firing_flag)
    else $error("bridge flag missed firing");
  chk_overspeed_cmp: assert property (1 |=> overspeed_flag == $past(speed_feedback > 12'sh3E8))
    else $error("overspeed flag wrong");
  chk_zero_indicator: assert property (zero_speed_indicator == !(forward_running_flag || reverse_running_flag))
    else $error("zero speed indicator wrong");
  chk_direction_excl: assert property (!(forward_running_flag && reverse_running_flag))
    else $error("both direction flags set");
  chk_peak_trip: assert property (current_peak_over |=> overcurrent_peak_flag && !firing_enable && !drive_ok_flag)
    else $error("peak did not trip");
  chk_trip_freeze: assert property (overcurrent_peak_flag |=> $stable(speed_readout))
    else $error("readout moved while tripped");
  chk_feedback_gate: assert property (speed_feedback_absent && firing_angle > 11'h2FF |=> speed_feedback_missing_flag)
    else $error("feedback loss missed");
  chk_clamp_hold: assert property (clamp_active |=> armature_voltage_limited <= $past(armature_voltage_limited))
    else $error("voltage rose under clamp");
  chk_watchdog_expiry: assert property (idle_reg > WATCHDOG_LIMIT + 24'h000004 |-> watchdog_fault_flag && !drive_ok_flag)
    else $error("watchdog expiry missed");
  chk_fault_sticky: assert property (watchdog_fault_flag |=> watchdog_fault_flag)
    else $error("watchdog fault dropped");
endmodule // drive_status_checker

bind drive_status_flags drive_status_checker #(.WATCHDOG_LIMIT(WATCHDOG_LIMIT)) chk (.*);

/* tb/tb_drive_status_flags.sv */
// self-checking bench for the drive status flag block
`timescale 1ns/100ps
module tb_drive_status_flags;
  logic clock = 0;
  logic sys_rst = 1;
  logic signed [11:0] speed_feedback, final_speed_demand, pre_ramp_reference;
  logic signed [11:0] post_ramp_reference, current_feedback, speed_readout;
  logic [11:0] zero_speed_threshold, overload_threshold, armature_voltage_demand;
  logic [11:0] armature_voltage_limited, current_readout;
  logic [15:0] overload_rise_rate, overload_fall_rate;
  logic [10:0] firing_angle;
  logic [23:0] overload_readout, ov;
  logic encoder_selected, encoder_a, encoder_b, current_demand_limited, forward_bridge_fire;
  logic reverse_bridge_fire, standstill_phaseback, clamp_active, phase_order_l1_l2_l3;
  logic field_current_absent, direct_firing_selected, speed_feedback_absent;
  logic feedback_loss_disable, phase_missing, supply_loss_disable, current_peak_over;
  logic watchdog_restart, forward_running_flag, reverse_running_flag, current_limit_flag;
  logic forward_bridge_firing_flag, reverse_bridge_firing_flag, standstill_phaseback_flag;
  logic at_speed_flag, overspeed_flag, zero_speed_flag, zero_speed_indicator;
  logic voltage_clamp_flag, phase_sequence_flag, drive_ok_flag, overload_alarm_flag;
  logic alarm_indicator, field_failure_flag, speed_feedback_missing_flag, phase_missing_flag;
  logic overcurrent_peak_flag, sustained_overload_flag, watchdog_fault_flag, firing_enable;
  logic [1:0] quad [4] = '{2'b00, 2'b10, 2'b11, 2'b01};
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;
  int i;
  bit wd_on = 1;
  drive_status_flags #(.WATCHDOG_LIMIT(24'h000014)) dut (.*);
  always #10 clock = ~clock;
  task automatic step(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic do_reset();
    sys_rst = 1;
    step(10);
    sys_rst = 0;
    step(3);
  endtask
  task automatic stop_test();
    if (mismatches == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // periodic watchdog restart and run ceiling
  always @(negedge clock)
  begin
    cycles <= cycles + 1;
    watchdog_restart <= wd_on && (cycles % 8 == 0);
    if (cycles == 2000)
    begin
      mismatches++;
      stop_test();
    end
  end
  initial
  begin
    {speed_feedback, final_speed_demand, pre_ramp_reference, post_ramp_reference,
     current_feedback, zero_speed_threshold, overload_threshold, armature_voltage_demand,
     overload_rise_rate, overload_fall_rate, firing_angle, encoder_selected, encoder_a,
     encoder_b, current_demand_limited, forward_bridge_fire, reverse_bridge_fire,
     standstill_phaseback, clamp_active, phase_order_l1_l2_l3, field_current_absent,
     direct_firing_selected, speed_feedback_absent, feedback_loss_disable, phase_missing,
     supply_loss_disable, current_peak_over} = '0;
    step(9);
    chk("rst", {zero_speed_flag, zero_speed_indicator, drive_ok_flag}, 3'b110);
    step(1);
    sys_rst = 0;
    step(3);
    chk("ok", drive_ok_flag, 1);
    zero_speed_threshold = 12'h014;
    for (i = 0; i < 3; i++)
    begin
      speed_feedback = (i == 0) ? 12'sh064 : (i == 1) ? -12'sh064 : 12'sh00A;
      step(2);
      chk("dir", {forward_running_flag, reverse_running_flag}, (i == 0) * 2 + (i == 1));
      chk("zero", {zero_speed_flag, zero_speed_indicator}, (i == 2) * 3);
    end
    encoder_selected = 1;
    speed_feedback = 12'sh064;
    for (i = 0; i < 8; i++)
    begin
      {encoder_a, encoder_b} = quad[(i < 4) ? i : 7 - i];
      step(2);
      if (i == 3 || i == 7)
        chk("enc", {forward_running_flag, reverse_running_flag}, (i == 3) ? 2 : 1);
    end
    encoder_selected = 0;
    for (i = 0; i < 7; i++)
    begin
      {current_demand_limited, forward_bridge_fire, reverse_bridge_fire, standstill_phaseback,
       clamp_active, phase_order_l1_l2_l3} = 6'h20 >> i;
      step(2);
      chk("bits", {current_limit_flag, forward_bridge_firing_flag, reverse_bridge_firing_flag,
        standstill_phaseback_flag, voltage_clamp_flag, phase_sequence_flag}, 6'h20 >> i);
    end
    armature_voltage_demand = 12'h064;
    step(2);
    clamp_active = 1;
    armature_voltage_demand = 12'h0C8;
    step(2);
    chk("clamp", armature_voltage_limited, 12'h064);
    clamp_active = 0;
    pre_ramp_reference = 12'sh1F4;
    post_ramp_reference = 12'sh1F4;
    final_speed_demand = 12'sh1F4;
    for (i = 0; i < 3; i++)
    begin
      speed_feedback = (i == 1) ? 12'sh203 : 12'sh1FE;
      post_ramp_reference = (i == 2) ? 12'sh1F3 : 12'sh1F4;
      step(2);
      chk("at_speed", at_speed_flag, i == 0);
    end
    speed_feedback = 12'sh3E8;
    step(2);
    chk("os_1000", overspeed_flag, 0);
    speed_feedback = 12'sh3E9;
    step(2);
    chk("os_1001", {overspeed_flag, drive_ok_flag}, 2'b11);
    speed_feedback = 12'sh000;
    overload_threshold = 12'h064;
    overload_rise_rate = 16'hFFFF;
    overload_fall_rate = 16'h0100;
    current_feedback = 12'sh258;
    step(3);
    chk("alarm", overload_alarm_flag, 1);
    chk("alarm_led", alarm_indicator, 0);
    chk("i_read", current_readout, 12'h258);
    current_feedback = 12'sh000;
    step(2);
    ov = overload_readout;
    step(2);
    chk("fall", overload_readout < ov, 1);
    current_feedback = 12'sh258;
    for (i = 0; i < 60 && !sustained_overload_flag; i++)
      step(1);
    chk("ixt", {sustained_overload_flag, drive_ok_flag, firing_enable}, 3'b100);
    current_feedback = 12'sh000;
    do_reset();
    field_current_absent = 1;
    direct_firing_selected = 1;
    step(2);
    chk("field", {field_failure_flag, drive_ok_flag}, 2'b11);
    direct_firing_selected = 0;
    step(2);
    chk("field_trip", drive_ok_flag, 0);
    field_current_absent = 0;
    do_reset();
    speed_feedback_absent = 1;
    firing_angle = 11'h2FF;
    step(2);
    chk("fb_767", {speed_feedback_missing_flag, drive_ok_flag}, 2'b01);
    firing_angle = 11'h300;
    feedback_loss_disable = 1;
    step(2);
    chk("fb_off", {speed_feedback_missing_flag, drive_ok_flag}, 2'b11);
    feedback_loss_disable = 0;
    step(2);
    chk("fb_trip", drive_ok_flag, 0);
    speed_feedback_absent = 0;
    do_reset();
    phase_missing = 1;
    supply_loss_disable = 1;
    step(2);
    chk("sup_off", {phase_missing_flag, drive_ok_flag}, 2'b01);
    supply_loss_disable = 0;
    step(2);
    chk("sup", {phase_missing_flag, drive_ok_flag}, 2'b10);
    phase_missing = 0;
    do_reset();
    speed_feedback = 12'sh064;
    step(2);
    current_peak_over = 1;
    step(1);
    current_peak_over = 0;
    speed_feedback = 12'sh12C;
    step(2);
    chk("peak", {overcurrent_peak_flag, firing_enable, drive_ok_flag}, 3'b100);
    chk("frozen", speed_readout, 12'h064);
    do_reset();
    chk("live", speed_readout, 12'h12C);
    wd_on = 0;
    step(30);
    chk("wd", {watchdog_fault_flag, drive_ok_flag}, 2'b10);
    wd_on = 1;
    do_reset();
    chk("wd_clr", watchdog_fault_flag, 0);
    stop_test();
  end
endmodule // tb_drive_status_flags
